// *** hw/dmc_mem_ctrl_regs.sv ***
// memory-control register group of the display controller and the
// controls it steers; assumes the sequencer index/data host port,
// a 200 MHz memory clock on sys_clk_in and synchronous inputs
//
// Behaviour
// - dac command 4 high 12 low, or 8 high 24 low when width bit set.
// - burst writes from legacy path unless burst disable bit is set.
// - eight-entry fetch fifo refills at two, or four, empty entries.
// - refresh requests made unless refresh disable bit is set.
// - policy bit set forces exactly one refresh per scan line.
// - banked mode address is bank-high bits 5..0 above host bits 15..0.
// - type and timing register loaded from eight data-bus straps on the first clock after reset.
// - internal logic runs at half memory clock, or full when bit set.
// - memory data bus is 32 bits, or 64 bits when bit set.
// - column bits: 10 for 0x, 8 for 10, 9 for 11.
// - external memory used unless external disable bit is set.
// - activate to precharge at least 7 clocks, or 6 when bit set.
// - refresh to next command waits 10 clocks, or 9 when bit set.
// - registers reached through data port 3C5h by index value.
// - memory control register clears to zero on reset.
`timescale 1ns/1ps
`include "dmc_consts.svh"
module dmc_mem_ctrl_regs
    import dmc_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    // host i/o port
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_wr_in,
    input  wire logic        io_rd_in,
    input  wire logic [7:0]  io_wdata_in,
    output logic      [7:0]  io_rdata_out,
    // straps on the memory data bus
    input  wire logic [7:0]  mem_data_straps_in,
    // palette dac command
    input  wire logic        dac_cmd_req_in,
    output logic             dac_cmd_out,
    output logic             dac_busy_out,
    // fetch fifo
    input  wire logic [3:0]  fifo_empty_count_in,
    output logic             fifo_refill_req_out,
    // refresh
    input  wire logic        line_start_in,
    output logic             refresh_req_out,
    // host addressing
    input  wire logic        linear_addressing_ctrl_in,
    input  wire logic [21:0] host_addr_in,
    output logic      [21:0] mem_addr_out,
    // sdram sequencing
    input  wire logic        activate_in,
    input  wire logic        refresh_issued_in,
    output logic             precharge_ok_out,
    output logic             cmd_after_refresh_ok_out,
    // configuration to the memory path
    output logic             burst_write_en_out,
    output logic             int_clk_en_out,
    output logic             bus_64_out,
    output logic      [3:0]  col_bits_out,
    output logic             ext_mem_en_out
);

    logic [7:0]  index_ff;
    logic [7:0]  mem_control_ff;
    logic [7:0]  bank_address_high_ff;
    logic [7:0]  memory_type_timing_ff;
    logic        strap_done_ff;
    logic        half_phase_ff;
    logic [11:0] refresh_cnt_ff;

    // host port decode
    wire sel_index_w = (io_addr_in == `DMC_IO_INDEX_ADDR);
    wire sel_data_w  = (io_addr_in == `DMC_IO_DATA_ADDR);
    wire wr_index_w  = io_wr_in && sel_index_w;
    wire wr_data_w   = io_wr_in && sel_data_w;
    wire hit_ctrl_w  = (index_ff == `DMC_IDX_MEM_CTRL);
    wire hit_bank_w  = (index_ff == `DMC_IDX_BANK_HIGH);
    wire hit_type_w  = (index_ff == `DMC_IDX_TYPE_TIMING);

    // register fields
    wire refresh_policy_w  = mem_control_ff[`DMC_MC_REFRESH_POLICY];
    wire refresh_dis_w     = mem_control_ff[`DMC_MC_REFRESH_DIS];
    wire fifo_thresh_w     = mem_control_ff[`DMC_MC_FIFO_THRESH];
    wire burst_dis_w       = mem_control_ff[`DMC_MC_BURST_DIS];
    wire dac_width_w       = mem_control_ff[`DMC_MC_DAC_WIDTH];
    wire ref_cmd_fast_w    = memory_type_timing_ff[`DMC_MT_REFRESH_CMD];
    wire act_pre_fast_w    = memory_type_timing_ff[`DMC_MT_ACT_PRE];
    wire ext_dis_w         = memory_type_timing_ff[`DMC_MT_EXT_DIS];
    wire col_hi_w          = memory_type_timing_ff[`DMC_MT_COL_HI];
    wire col_lo_w          = memory_type_timing_ff[`DMC_MT_COL_LO];
    wire bus_width_w       = memory_type_timing_ff[`DMC_MT_BUS_WIDTH];
    wire clk_ratio_w       = memory_type_timing_ff[`DMC_MT_CLK_RATIO];

    // reserved bits 7:6 and 2 of memory_control read back as zero
    wire [7:0] nxt_mem_control = io_wdata_in & `DMC_MC_WRITE_MASK;

    wire [7:0] rd_reg_w = hit_ctrl_w ? mem_control_ff
                        : hit_bank_w ? bank_address_high_ff
                        : hit_type_w ? memory_type_timing_ff
                        : 8'h00;
    wire [7:0] nxt_rdata = sel_index_w ? index_ff
                         : sel_data_w  ? rd_reg_w
                         : 8'h00;

    function automatic dmc_count_t pick_len(input logic sel,
                                            input dmc_count_t len0,
                                            input dmc_count_t len1);
        pick_len = sel ? len1 : len0;
    endfunction : pick_len

    wire dmc_count_t dac_high_w = pick_len(dac_width_w,
        `DMC_DAC_HIGH_SHORT, `DMC_DAC_HIGH_LONG);
    wire dmc_count_t dac_low_w = pick_len(dac_width_w,
        `DMC_DAC_LOW_SHORT, `DMC_DAC_LOW_LONG);
    wire dmc_count_t act_pre_w = pick_len(act_pre_fast_w,
        `DMC_ACT_PRE_SLOW, `DMC_ACT_PRE_FAST);
    wire dmc_count_t ref_cmd_w = pick_len(ref_cmd_fast_w,
        `DMC_REF_CMD_SLOW, `DMC_REF_CMD_FAST);

    wire [3:0] refill_lvl_w = fifo_thresh_w ? `DMC_FIFO_LVL_HIGH
                                            : `DMC_FIFO_LVL_LOW;
    wire       nxt_refill   = (fifo_empty_count_in >= refill_lvl_w);

    wire [3:0] nxt_col_bits = !col_hi_w ? `DMC_COL_BITS_10
                            : col_lo_w  ? `DMC_COL_BITS_9
                            : `DMC_COL_BITS_8;

    // banked window is 64K; only the low six bank bits fit a 22-bit space
    wire [21:0] nxt_mem_addr = linear_addressing_ctrl_in ? host_addr_in
        : {bank_address_high_ff[5:0], host_addr_in[15:0]};

    // refresh scheduling: periodic, or one per scan line
    wire refresh_wrap_w = (refresh_cnt_ff == `DMC_REFRESH_LAST);
    wire [11:0] nxt_refresh_cnt = (refresh_dis_w || refresh_wrap_w)
                                ? 12'h000 : refresh_cnt_ff + 12'h001;
    wire nxt_refresh_req = !refresh_dis_w && (refresh_policy_w
                         ? line_start_in : refresh_wrap_w);

    // a new request during the recovery phase is dropped, not queued
    dmc_dac_pulse u_dac_pulse
    (
        .sys_clk_in  (sys_clk_in),
        .arst_n_in   (arst_n_in),
        .req_in      (dac_cmd_req_in),
        .high_len_in (dac_high_w),
        .low_len_in  (dac_low_w),
        .cmd_out     (dac_cmd_out),
        .busy_out    (dac_busy_out)
    );

    dmc_gap_timer u_act_pre
    (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .start_in   (activate_in),
        .len_in     (act_pre_w),
        .ready_out  (precharge_ok_out)
    );

    dmc_gap_timer u_ref_cmd
    (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .start_in   (refresh_issued_in),
        .len_in     (ref_cmd_w),
        .ready_out  (cmd_after_refresh_ok_out)
    );

    // index persists between data-port accesses
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            index_ff <= `DMC_INDEX_RST;
        end
        else if (wr_index_w)
        begin
            index_ff <= io_wdata_in;
        end
    end

    // reserved bits are masked on the way in, so they read back as zero
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mem_control_ff <= `DMC_MEM_CTRL_RST;
        end
        else if (wr_data_w && hit_ctrl_w)
        begin
            mem_control_ff <= nxt_mem_control;
        end
    end

    // bank bits above the 64K host window
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            bank_address_high_ff <= `DMC_BANK_HIGH_RST;
        end
        else if (wr_data_w && hit_bank_w)
        begin
            bank_address_high_ff <= io_wdata_in;
        end
    end

    // read data holds between reads
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            io_rdata_out <= 8'h00;
        end
        else if (io_rd_in)
        begin
            io_rdata_out <= nxt_rdata;
        end
    end

    // straps cannot be taken under the asynchronous reset itself, so
    // they are sampled on the first edge after release
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            strap_done_ff         <= 1'b0;
            memory_type_timing_ff <= 8'h00;
        end
        else
        begin
            strap_done_ff <= 1'b1;
            if (!strap_done_ff)
                memory_type_timing_ff <= mem_data_straps_in;
            else if (wr_data_w && hit_type_w)
                memory_type_timing_ff <= io_wdata_in;
        end
    end

    // internal clock enable: every cycle, or every other one at half rate
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            half_phase_ff  <= 1'b0;
            int_clk_en_out <= 1'b0;
        end
        else
        begin
            half_phase_ff  <= !half_phase_ff;
            int_clk_en_out <= clk_ratio_w || half_phase_ff;
        end
    end

    // refresh counter is held at zero while requests are disabled
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            refresh_cnt_ff  <= 12'h000;
            refresh_req_out <= 1'b0;
        end
        else
        begin
            refresh_cnt_ff  <= nxt_refresh_cnt;
            refresh_req_out <= nxt_refresh_req;
        end
    end

    // fetch refill request and memory address
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            fifo_refill_req_out <= 1'b0;
            mem_addr_out        <= 22'h000000;
        end
        else
        begin
            fifo_refill_req_out <= nxt_refill;
            mem_addr_out        <= nxt_mem_addr;
        end
    end

    // memory path configuration follows the registers one clock later
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            burst_write_en_out <= 1'b0;
            bus_64_out         <= 1'b0;
            col_bits_out       <= 4'h0;
            ext_mem_en_out     <= 1'b0;
        end
        else
        begin
            burst_write_en_out <= !burst_dis_w;
            bus_64_out         <= bus_width_w;
            col_bits_out       <= nxt_col_bits;
            ext_mem_en_out     <= strap_done_ff && !ext_dis_w;
        end
    end

endmodule : dmc_mem_ctrl_regs

// *** hw/dmc_consts.svh ***
// offsets, field positions, reset values and timing counts of the
// memory-control register group; assumes a 200 MHz memory clock
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

// indexed host port
`define DMC_IO_INDEX_ADDR     16'h03c4
`define DMC_IO_DATA_ADDR      16'h03c5
`define DMC_IDX_MEM_CTRL      8'h60
`define DMC_IDX_BANK_HIGH     8'h61
`define DMC_IDX_TYPE_TIMING   8'h62

// reset values
`define DMC_MEM_CTRL_RST      8'h00
`define DMC_BANK_HIGH_RST     8'h00
`define DMC_INDEX_RST         8'h00

// memory_control fields
`define DMC_MC_REFRESH_POLICY 0
`define DMC_MC_REFRESH_DIS    1
`define DMC_MC_FIFO_THRESH    3
`define DMC_MC_BURST_DIS      4
`define DMC_MC_DAC_WIDTH      5
`define DMC_MC_WRITE_MASK     8'h3b

// memory_type_timing fields
`define DMC_MT_REFRESH_CMD    0
`define DMC_MT_ACT_PRE        1
`define DMC_MT_EXT_DIS        2
`define DMC_MT_COL_LO         4
`define DMC_MT_COL_HI         5
`define DMC_MT_BUS_WIDTH      6
`define DMC_MT_CLK_RATIO      7

// dac command pulse, in memory clocks
`define DMC_DAC_HIGH_SHORT    5'd4
`define DMC_DAC_LOW_SHORT     5'd12
`define DMC_DAC_HIGH_LONG     5'd8
`define DMC_DAC_LOW_LONG      5'd24

// sdram timings, in memory clocks
`define DMC_ACT_PRE_SLOW      5'd7
`define DMC_ACT_PRE_FAST      5'd6
`define DMC_REF_CMD_SLOW      5'd10
`define DMC_REF_CMD_FAST      5'd9

// column address bit counts
`define DMC_COL_BITS_8        4'd8
`define DMC_COL_BITS_9        4'd9
`define DMC_COL_BITS_10       4'd10

// fetch fifo refill levels (empty entries)
`define DMC_FIFO_LVL_LOW      4'd2
`define DMC_FIFO_LVL_HIGH     4'd4

// normal refresh interval
`define DMC_CLK_PERIOD_NS     5
`define DMC_REFRESH_NS        15600
`define DMC_REFRESH_CYC       (`DMC_REFRESH_NS / `DMC_CLK_PERIOD_NS)
`define DMC_REFRESH_LAST      12'(`DMC_REFRESH_CYC - 1)

`endif

// *** hw/dmc_pkg.sv ***
// types shared by the memory-control register group
// assumes dmc_consts.svh is compiled alongside
package dmc_pkg;

    typedef enum logic [1:0] {
        DMC_DAC_IDLE = 2'b00,
        DMC_DAC_HIGH = 2'b01,
        DMC_DAC_LOW  = 2'b10
    } dmc_dac_state_e;

    typedef logic [4:0] dmc_count_t;

endpackage : dmc_pkg

// *** hw/dmc_gap_timer.sv ***
// minimum-gap timer: after start, ready stays low for len clocks
// assumes len is at least 1 and stable while counting
`timescale 1ns/1ps
module dmc_gap_timer
    import dmc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       start_in,
    input  wire dmc_count_t len_in,
    output logic            ready_out
);

    dmc_count_t cnt_ff;
    dmc_count_t nxt_cnt;
    logic       ready_ff;

    assign nxt_cnt = start_in ? len_in
                   : (cnt_ff != 5'h00) ? cnt_ff - 5'h01 : cnt_ff;
    assign ready_out = ready_ff;

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_ff   <= 5'h00;
            ready_ff <= 1'b1;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;
            ready_ff <= (nxt_cnt == 5'h00);
        end
    end

endmodule : dmc_gap_timer

// *** hw/dmc_dac_pulse.sv ***
// palette dac read/write command pulse: high phase then low recovery
// requests arriving while busy are ignored; only the idle state accepts one
`timescale 1ns/1ps
module dmc_dac_pulse
    import dmc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       req_in,
    input  wire dmc_count_t high_len_in,
    input  wire dmc_count_t low_len_in,
    output logic            cmd_out,
    output logic            busy_out
);

    dmc_dac_state_e state_ff;
    dmc_dac_state_e nxt_state;
    dmc_count_t     cnt_ff;
    dmc_count_t     nxt_cnt;
    logic           last_w;

    assign last_w = (cnt_ff == 5'h01);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = (cnt_ff != 5'h00) ? cnt_ff - 5'h01 : cnt_ff;
        unique case (state_ff)
            DMC_DAC_IDLE:
            begin
                if (req_in)
                begin
                    nxt_state = DMC_DAC_HIGH;
                    nxt_cnt   = high_len_in;
                end
            end
            DMC_DAC_HIGH:
            begin
                if (last_w)
                begin
                    nxt_state = DMC_DAC_LOW;
                    nxt_cnt   = low_len_in;
                end
            end
            DMC_DAC_LOW:
            begin
                if (last_w)
                begin
                    nxt_state = DMC_DAC_IDLE;
                end
            end
            default:
            begin
                nxt_state = DMC_DAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_ff <= DMC_DAC_IDLE;
            cnt_ff   <= 5'h00;
            cmd_out  <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            cmd_out  <= (nxt_state == DMC_DAC_HIGH);
            busy_out <= (nxt_state != DMC_DAC_IDLE);
        end
    end

endmodule : dmc_dac_pulse

// *** bench/dmc_mem_model.sv ***
// memory devices on the far side: strap levels on the data bus
// assumes straps are held by resistors, so the levels stand all the time
`timescale 1ns/1ps
module dmc_mem_model #(
    parameter logic [7:0] STRAPS = 8'hb2
) (
    output logic [7:0] mem_data_straps_out
);
    // pull resistors hold the level; no release to model here
    assign mem_data_straps_out = STRAPS;
endmodule : dmc_mem_model

// *** bench/dmc_mem_ctrl_regs_props.sv ***
// port assertions of the memory-control register group
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module dmc_mem_ctrl_regs_props (
    input wire logic        sys_clk_in,
    input wire logic        arst_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic        io_rd_in,
    input wire logic [7:0]  io_rdata_out,
    input wire logic        dac_cmd_out,
    input wire logic        dac_busy_out,
    input wire logic [3:0]  fifo_empty_count_in,
    input wire logic        fifo_refill_req_out,
    input wire logic        refresh_req_out,
    input wire logic        linear_addressing_ctrl_in,
    input wire logic [21:0] host_addr_in,
    input wire logic [21:0] mem_addr_out,
    input wire logic        activate_in,
    input wire logic        refresh_issued_in,
    input wire logic        precharge_ok_out,
    input wire logic        cmd_after_refresh_ok_out,
    input wire logic        int_clk_en_out,
    input wire logic [3:0]  col_bits_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    property p_dac_high; $rose(dac_cmd_out) |-> dac_cmd_out[*4]; endproperty
    a_dac_high: assert property (p_dac_high)
        else $error("dac command high phase too short");
    property p_dac_busy;
        $rose(dac_busy_out) |-> dac_busy_out[*8] ##1 dac_busy_out[*8];
    endproperty
    a_dac_busy: assert property (p_dac_busy)
        else $error("dac busy shorter than sixteen clocks");
    property p_ref_pulse; refresh_req_out |=> !refresh_req_out; endproperty
    a_ref_pulse: assert property (p_ref_pulse)
        else $error("refresh request longer than one clock");
    property p_fifo_low;
        fifo_empty_count_in < 4'd2 |=> !fifo_refill_req_out;
    endproperty
    a_fifo_low: assert property (p_fifo_low)
        else $error("refill requested below two empty entries");
    property p_act_pre; activate_in |=> (!precharge_ok_out)[*6]; endproperty
    a_act_pre: assert property (p_act_pre)
        else $error("precharge allowed too early");
    property p_ref_cmd;
        refresh_issued_in |=> (!cmd_after_refresh_ok_out)[*8];
    endproperty
    a_ref_cmd: assert property (p_ref_cmd)
        else $error("command allowed too early after refresh");
    property p_cols;
        $past(arst_n_in, 2) |-> col_bits_out inside {4'd8, 4'd9, 4'd10};
    endproperty
    a_cols: assert property (p_cols)
        else $error("column bit count out of range");
    property p_addr_lin;
        linear_addressing_ctrl_in |=> mem_addr_out == $past(host_addr_in);
    endproperty
    a_addr_lin: assert property (p_addr_lin)
        else $error("linear address not passed through");
    property p_addr_bank;
        !linear_addressing_ctrl_in
            |=> mem_addr_out[15:0] == 16'($past(host_addr_in));
    endproperty
    a_addr_bank: assert property (p_addr_bank)
        else $error("banked address low half wrong");
    property p_bad_addr;
        io_rd_in && io_addr_in[15:1] != 15'h01e2 |=> io_rdata_out == 8'h00;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped port read not zero");
    property p_clk_ratio;
        $past(arst_n_in, 2) && !int_clk_en_out |=> int_clk_en_out;
    endproperty
    a_clk_ratio: assert property (p_clk_ratio)
        else $error("internal clock enable low two clocks");
    c_dac: cover property ($rose(dac_cmd_out));
    c_refresh: cover property (refresh_req_out);
    c_bank: cover property (!linear_addressing_ctrl_in ##1 mem_addr_out != 0);
endmodule : dmc_mem_ctrl_regs_props

bind dmc_mem_ctrl_regs dmc_mem_ctrl_regs_props
    dmc_mem_ctrl_regs_props_inst (.*);

// *** bench/dmc_mem_ctrl_regs_tb_top.sv ***
// testbench of the memory-control register group
// assumes the strap model on the data bus and a 200 MHz clock
`timescale 1ns/1ps
`include "dmc_consts.svh"
module dmc_mem_ctrl_regs_tb_top;
    localparam logic [7:0] STRAPS = 8'hb2;
    logic        sys_clk_in = 1'b0;
    logic        arst_n_in, io_wr_in, io_rd_in, dac_cmd_req_in;
    logic [15:0] io_addr_in;
    logic [7:0]  io_wdata_in, io_rdata_out, mem_data_straps_in, v;
    logic        dac_cmd_out, dac_busy_out, fifo_refill_req_out;
    logic [3:0]  fifo_empty_count_in, col_bits_out;
    logic        line_start_in, refresh_req_out, linear_addressing_ctrl_in;
    logic [21:0] host_addr_in, mem_addr_out;
    logic        activate_in, refresh_issued_in, precharge_ok_out;
    logic        cmd_after_refresh_ok_out, burst_write_en_out;
    logic        int_clk_en_out, bus_64_out, ext_mem_en_out;
    int          bad_count, compares, n, m;

    dmc_mem_ctrl_regs dmc_mem_ctrl_regs_inst (.*);
    dmc_mem_model #(.STRAPS(STRAPS)) dmc_mem_model_inst (
        .mem_data_straps_out(mem_data_straps_in)
    );

    always #2.5 sys_clk_in = ~sys_clk_in;

    task check(input logic [21:0] seen, input logic [21:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task wr_reg(input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk_in);
        io_addr_in  <= `DMC_IO_INDEX_ADDR;
        io_wdata_in <= idx;
        io_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        io_addr_in  <= `DMC_IO_DATA_ADDR;
        io_wdata_in <= d;
        @(posedge sys_clk_in);
        io_wr_in    <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask : wr_reg

    // index first, then a read from addr (data port or an unmapped one)
    task rd_reg(input logic [7:0] idx, input logic [15:0] addr);
        wr_reg(8'h00, 8'h00);
        @(posedge sys_clk_in);
        io_addr_in  <= `DMC_IO_INDEX_ADDR;
        io_wdata_in <= idx;
        io_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        io_addr_in  <= addr;
        io_wr_in    <= 1'b0;
        io_rd_in    <= 1'b1;
        @(posedge sys_clk_in);
        io_rd_in    <= 1'b0;
        @(posedge sys_clk_in);
        #1 v = io_rdata_out;
    endtask : rd_reg

    // sel 0 measures activate to precharge, sel 1 refresh to command
    task timer_len(input logic sel);
        @(posedge sys_clk_in);
        activate_in       <= !sel;
        refresh_issued_in <= sel;
        @(posedge sys_clk_in);
        activate_in       <= 1'b0;
        refresh_issued_in <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        while (!(sel ? cmd_after_refresh_ok_out : precharge_ok_out) && n < 40);
    endtask : timer_len

    task dac_run(input int hi, input int busy);
        @(posedge sys_clk_in);
        dac_cmd_req_in <= 1'b1;
        n = 0;
        m = 0;
        do
        begin
            @(posedge sys_clk_in);
            dac_cmd_req_in <= 1'b0;
            #1 n += int'(dac_cmd_out);
            m += int'(dac_busy_out);
        end
        while (dac_busy_out && m < 60);
        check(22'(n), 22'(hi));
        check(22'(m), 22'(hi + busy));
    endtask : dac_run

    // counts refresh pulses; line starts every period clocks if nonzero
    task ref_count(input int cycles, input int period);
        n = 0;
        for (int i = 0; i < cycles; i++)
        begin
            @(posedge sys_clk_in);
            line_start_in <= (period != 0) && (i % period == 0);
            @(negedge sys_clk_in);
            n += int'(refresh_req_out);
        end
    endtask : ref_count

    task fifo_sweep(input int lvl);
        for (int c = 0; c <= 8; c++)
        begin
            @(posedge sys_clk_in);
            fifo_empty_count_in <= 4'(c);
            repeat (2) @(posedge sys_clk_in);
            #1 check(22'(fifo_refill_req_out), 22'(c >= lvl));
        end
    endtask : fifo_sweep

    // expected decodes worked out from the type and timing byte t
    task type_chk(input logic [7:0] t);
        rd_reg(`DMC_IDX_TYPE_TIMING, `DMC_IO_DATA_ADDR);
        check(22'(v), 22'(t));
        check(22'(col_bits_out), !t[5] ? 22'd10 : t[4] ? 22'd9 : 22'd8);
        check(22'(bus_64_out), 22'(t[6]));
        check(22'(ext_mem_en_out), 22'(!t[2]));
        @(negedge sys_clk_in);
        m = int'(int_clk_en_out);
        @(negedge sys_clk_in);
        check(22'(m + int'(int_clk_en_out)), 22'(t[7] ? 2 : 1));
        timer_len(1'b0);
        check(22'(n), t[1] ? 22'd6 : 22'd7);
        timer_len(1'b1);
        check(22'(n), t[0] ? 22'd9 : 22'd10);
    endtask : type_chk

    task t_reset_vals;
        rd_reg(`DMC_IDX_MEM_CTRL, `DMC_IO_DATA_ADDR);
        check(22'(v), 22'h00);
        check(22'(burst_write_en_out), 22'h1);
        rd_reg(`DMC_IDX_BANK_HIGH, `DMC_IO_DATA_ADDR);
        check(22'(v), 22'h00);
        rd_reg(`DMC_IDX_TYPE_TIMING, 16'h03d4);
        check(22'(v), 22'h00);
        type_chk(STRAPS);
    endtask : t_reset_vals

    task t_ctrl;
        wr_reg(`DMC_IDX_MEM_CTRL, 8'hff);
        rd_reg(`DMC_IDX_MEM_CTRL, `DMC_IO_DATA_ADDR);
        check(22'(v), 22'h3b);
        check(22'(burst_write_en_out), 22'h0);
        fifo_sweep(4);
        dac_run(8, 24);
        ref_count(3200, 400);
        check(22'(n), 22'd0);
        wr_reg(`DMC_IDX_MEM_CTRL, 8'h00);
        fifo_sweep(2);
        dac_run(4, 12);
        dac_run(4, 12);
        ref_count(3120, 0);
        check(22'(n), 22'd1);
        wr_reg(`DMC_IDX_MEM_CTRL, 8'h01);
        ref_count(3200, 400);
        check(22'(n), 22'd8);
    endtask : t_ctrl

    task t_bank;
        wr_reg(`DMC_IDX_BANK_HIGH, 8'h2a);
        host_addr_in <= 22'h3f1234;
        repeat (2) @(posedge sys_clk_in);
        #1 check(mem_addr_out, 22'h2a1234);
        linear_addressing_ctrl_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #1 check(mem_addr_out, 22'h3f1234);
    endtask : t_bank

    initial
    begin
        {arst_n_in, io_wr_in, io_rd_in, dac_cmd_req_in, io_addr_in} = '0;
        {io_wdata_in, fifo_empty_count_in, line_start_in, host_addr_in} = '0;
        {linear_addressing_ctrl_in, activate_in, refresh_issued_in} = '0;
        repeat (3) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        t_reset_vals();
        t_ctrl();
        t_bank();
        wr_reg(`DMC_IDX_TYPE_TIMING, 8'h2f);
        type_chk(8'h2f);
        wr_reg(`DMC_IDX_TYPE_TIMING, 8'h40);
        type_chk(8'h40);
        results();
    end

    // the tests need about 10000 clocks; a hang is cut off well after
    initial
    begin
        repeat (30000) @(posedge sys_clk_in);
        bad_count++;
        results();
    end
endmodule : dmc_mem_ctrl_regs_tb_top
